/* File: tb/bcl_bench.sv */
// bcl_bench: self-checking bench for the boot configuration latches
module bcl_bench
  import bcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [BCL_WCNT_W-1:0] WCYC = BCL_WCNT_W'(2);

  logic                       clk;
  logic                       nrst;
  logic                       por_n;
  logic [BCL_ADDR_W-1:0]      avs_address;
  logic                       avs_read;
  logic                       avs_write;
  logic [31:0]                avs_writedata;
  logic [3:0]                 avs_byteenable;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest;
  logic [2*BCL_NUM_PORTS-1:0] port_reset_drive_mode;
  logic                       ext_reset_pin_select;
  logic                       debug_access_allow;
  logic                       boot_clock_speed;
  logic [1:0]                 debug_port_select;
  logic                       debug_ports_off;
  logic                       flash_ecc_use;
  logic                       ecc_bytes_as_data;
  logic [3:0]                 digital_clock_phase_delay;
  int                         n_errors;
  int                         n_compared;
  int                         cycles;
  logic [31:0]                rdat;
  logic [7:0]                 b3;

  bcl_top #(.WRITE_CYCLES(WCYC)) bcl_top_i
  (
    .clk                       (clk),
    .nrst                      (nrst),
    .por_n                     (por_n),
    .avs_address               (avs_address),
    .avs_read                  (avs_read),
    .avs_write                 (avs_write),
    .avs_writedata             (avs_writedata),
    .avs_byteenable            (avs_byteenable),
    .avs_readdata              (avs_readdata),
    .avs_waitrequest           (avs_waitrequest),
    .port_reset_drive_mode     (port_reset_drive_mode),
    .ext_reset_pin_select      (ext_reset_pin_select),
    .debug_access_allow        (debug_access_allow),
    .boot_clock_speed          (boot_clock_speed),
    .debug_port_select         (debug_port_select),
    .debug_ports_off           (debug_ports_off),
    .flash_ecc_use             (flash_ecc_use),
    .ecc_bytes_as_data         (ecc_bytes_as_data),
    .digital_clock_phase_delay (digital_clock_phase_delay)
  );

  // 100 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // hang guard, whole run needs under two hundred cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("wrong value timeout expected 0 seen %0d", cycles);
      complete_run();
    end
  end

  // one comparison of a value
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // wait for the slave answer, sampled at rising edges
  task automatic bus_wait();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 300);
    if (avs_waitrequest !== 1'b0)
      cmp("waitrequest", 32'h0, 32'(avs_waitrequest));
  endtask : bus_wait

  // avalon write, request held until waitrequest low
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    bus_wait();
    avs_write      <= 1'b0;
  endtask : wr

  // avalon read, data taken at the answer edge
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read    <= 1'b0;
  endtask : rd

  // read one register and compare
  task automatic rd_cmp(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    cmp("register", exp, d);
  endtask : rd_cmp

  // system reset pulse, applies the stored bytes
  task automatic nrst_pulse();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : nrst_pulse

  // decoded outputs against the four bytes
  task automatic check_cfg(input logic [7:0] b0, input logic [7:0] b1,
                           input logic [7:0] b2, input logic [7:0] c3);
    cmp("drive", 32'({b2[1:0], b1, b0}), 32'(port_reset_drive_mode));
    cmp("ext_reset", 32'(b2[7]), 32'(ext_reset_pin_select));
    cmp("debug_allow", 32'(b2[6]), 32'(debug_access_allow));
    cmp("speed", 32'(c3[0]), 32'(boot_clock_speed));
    cmp("dps", 32'(c3[2:1]), 32'(debug_port_select));
    cmp("dps_off", 32'(c3[2:1] == 2'h3), 32'(debug_ports_off));
    cmp("ecc", 32'(c3[3]), 32'(flash_ecc_use));
    cmp("ecc_data", 32'(!c3[3]), 32'(ecc_bytes_as_data));
    cmp("phase", 32'(c3[7:4]), 32'(digital_clock_phase_delay));
  endtask : check_cfg

  // main sequence
  initial
  begin
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    nrst = 1'b0;
    por_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    repeat (3) @(posedge clk);
    por_n <= 1'b1;
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // factory bytes and their decode
    check_cfg(8'h00, 8'h00, 8'h40, 8'h0a);
    rd_cmp(5'h00, 32'h0000_0000);
    rd_cmp(5'h04, 32'h0000_0000);
    rd_cmp(5'h08, 32'h0000_0040);
    rd_cmp(5'h0c, 32'h0000_000a);
    // all four drive codes, reserved bits and high data bits dropped
    wr(5'h00, 32'hffff_ffe4, 4'hf);
    wr(5'h04, 32'h0000_001b, 4'hf);
    wr(5'h08, 32'h0000_00fe, 4'hf);
    wr(5'h0c, 32'h0000_00a5, 4'hf);
    rd_cmp(5'h00, 32'h0000_00e4);
    rd_cmp(5'h08, 32'h0000_00c2);
    rd_cmp(5'h0c, 32'h0000_00a5);
    // outputs wait for the next system reset
    check_cfg(8'h00, 8'h00, 8'h40, 8'h0a);
    rd(5'h10, rdat);
    cmp("pending", 32'h1, rdat & 32'h1);
    cmp("wear", 32'h0000_0004, 32'(rdat[31:16]));
    nrst_pulse();
    check_cfg(8'he4, 8'h1b, 8'hc2, 8'ha5);
    rd(5'h10, rdat);
    cmp("pending", 32'h0, rdat & 32'h1);
    // every debug port code with speed, ecc and phase varied
    for (int i = 0; i < 4; i++)
    begin
      b3 = {4'(3 * i + 1), i[0], i[1:0], i[1]};
      wr(5'h0c, 32'(b3), 4'hf);
      nrst_pulse();
      check_cfg(8'he4, 8'h1b, 8'hc2, b3);
    end
    // refused accesses leave the latches alone
    rd_cmp(5'h14, 32'h0000_0000);
    rd_cmp(5'h0d, 32'h0000_0000);
    wr(5'h05, 32'h0000_0055, 4'hf);
    wr(5'h04, 32'h0000_0066, 4'h0);
    rd_cmp(5'h04, 32'h0000_001b);
    // bytes 2 and 3 back to factory values, applied at reset
    wr(5'h08, 32'h0000_0040, 4'hf);
    wr(5'h0c, 32'h0000_000a, 4'hf);
    nrst_pulse();
    check_cfg(8'he4, 8'h1b, 8'h40, 8'h0a);
    // ten committed writes, refused ones not counted
    rd(5'h10, rdat);
    cmp("wear", 32'h0000_000a, 32'(rdat[31:16]));
    cmp("pending", 32'h0, rdat & 32'h1);
    complete_run();
  end
endmodule : bcl_bench

/* File: verilog/bcl_latch_mem.sv */
// bcl_latch_mem: four-byte configuration latch array
module bcl_latch_mem
  import bcl_pkg::*;
(
  input wire logic clk,
  input wire logic por_n,
  bcl_mem_if.mem   mem
);

  logic [BCL_NUM_BYTES-1:0][7:0] cells_q;
  logic [7:0]                    rd_data_q;

  // cells only lose content on power-up, not system reset
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      cells_q <= {BCL_DFLT_BOOT_CLK, BCL_DFLT_RESET_DBG, BCL_DFLT_PORT_B, BCL_DFLT_PORT_A};
    end
    else if (mem.wr_en)
    begin
      cells_q[mem.wr_idx] <= mem.wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      rd_data_q <= 8'h00;
    end
    else if (mem.rd_en)
    begin
      rd_data_q <= cells_q[mem.rd_idx];
    end
  end

  assign mem.rd_data = rd_data_q;
  assign mem.cells   = cells_q;

endmodule : bcl_latch_mem

/* File: verilog/bcl_mem_if.sv */
// bcl_mem_if: link between bus logic and the latch array
interface bcl_mem_if
  import bcl_pkg::*;
;
  logic                            wr_en;
  logic [1:0]                      wr_idx;
  logic [7:0]                      wr_data;
  logic                            rd_en;
  logic [1:0]                      rd_idx;
  logic [7:0]                      rd_data;
  logic [BCL_NUM_BYTES-1:0][7:0]   cells;

  modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data, cells);
  modport mem  (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data, cells);
endinterface : bcl_mem_if

/* File: verilog/bcl_pkg.sv */
// bcl_pkg: constants for the boot configuration latch block
// Operation
// - four config bytes applied at every reset
// - two-bit field sets each port reset drive
// - one bit picks gpio or external reset
// - one bit blocks or permits debug access
// - one bit picks 12 or 48 MHz boot
// - two bits pick jtag5, jtag4, swd, off
// - ecc bit uses or frees ecc flash bytes
// - byte 3 nibble sets digital clock phase
package bcl_pkg;
  // latch array and bus geometry
  localparam int unsigned BCL_NUM_BYTES = 4;
  localparam int unsigned BCL_ADDR_W    = 5;
  localparam int unsigned BCL_NUM_PORTS = 9;
  // register indices; byte address is four times the index
  localparam logic [2:0]  BCL_IDX_PORT_A     = 3'h0;
  localparam logic [2:0]  BCL_IDX_PORT_B     = 3'h1;
  localparam logic [2:0]  BCL_IDX_RESET_DBG  = 3'h2;
  localparam logic [2:0]  BCL_IDX_BOOT_CLK   = 3'h3;
  localparam logic [2:0]  BCL_IDX_STATUS     = 3'h4;
  // field positions in byte 2
  localparam int unsigned BCL_XRES_BIT       = 7;
  localparam int unsigned BCL_DEBUG_ACCESS_ALLOW_BIT      = 6;
  localparam int unsigned BCL_P15_LSB        = 0;
  localparam logic [7:0]  BCL_RESET_DBG_MASK = 8'hc3;
  // field positions in byte 3
  localparam int unsigned BCL_PHS_LSB        = 4;
  localparam int unsigned BCL_ECC_BIT        = 3;
  localparam int unsigned BCL_DPS_LSB        = 1;
  localparam int unsigned BCL_SPEED_BIT      = 0;
  // port drive encodings
  localparam logic [1:0]  BCL_DRV_ANALOG_HIZ = 2'h0;
  localparam logic [1:0]  BCL_DRV_DIG_HIZ    = 2'h1;
  localparam logic [1:0]  BCL_DRV_PULL_UP    = 2'h2;
  localparam logic [1:0]  BCL_DRV_PULL_DOWN  = 2'h3;
  // debug port encodings
  localparam logic [1:0]  BCL_DPS_JTAG5      = 2'h0;
  localparam logic [1:0]  BCL_DPS_JTAG4      = 2'h1;
  localparam logic [1:0]  BCL_DPS_SWD        = 2'h2;
  localparam logic [1:0]  BCL_DPS_OFF        = 2'h3;
  // factory values of the four bytes
  localparam logic [7:0]  BCL_DFLT_PORT_A    = 8'h00;
  localparam logic [7:0]  BCL_DFLT_PORT_B    = 8'h00;
  localparam logic [7:0]  BCL_DFLT_RESET_DBG = 8'h40;
  localparam logic [7:0]  BCL_DFLT_BOOT_CLK  = 8'h0a;
  // bus side reset values
  localparam logic [31:0] BCL_RDATA_RST      = 32'h0000_0000;
  // latch program timing
  localparam int unsigned BCL_CLK_PERIOD_NS  = 10;
  localparam int unsigned BCL_NVL_WRITE_NS   = 1000;
  localparam int unsigned BCL_WRITE_CYCLES   =
    (BCL_NVL_WRITE_NS + BCL_CLK_PERIOD_NS - 1) / BCL_CLK_PERIOD_NS;
  localparam int unsigned BCL_WCNT_W         = 8;
  localparam int unsigned BCL_WEAR_W         = 16;
  // bus state machine
  typedef enum logic [1:0]
  {
    BCL_ST_IDLE   = 2'b00,
    BCL_ST_READ   = 2'b01,
    BCL_ST_WRITE  = 2'b10,
    BCL_ST_ANSWER = 2'b11
  } bcl_state_e;
endpackage : bcl_pkg

/* File: verilog/bcl_top.sv */
// bcl_top: boot configuration latches with avalon register access
//
// Chosen here: register access over Avalon-MM.
module bcl_top
  import bcl_pkg::*;
#(
  parameter logic [BCL_WCNT_W-1:0] WRITE_CYCLES = BCL_WCNT_W'(BCL_WRITE_CYCLES)
)(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       por_n,
  input  wire logic [BCL_ADDR_W-1:0]      avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  output logic      [2*BCL_NUM_PORTS-1:0] port_reset_drive_mode,
  output logic                            ext_reset_pin_select,
  output logic                            debug_access_allow,
  output logic                            boot_clock_speed,
  output logic      [1:0]                 debug_port_select,
  output logic                            debug_ports_off,
  output logic                            flash_ecc_use,
  output logic                            ecc_bytes_as_data,
  output logic      [3:0]                 digital_clock_phase_delay
);

  bcl_mem_if mif ();

  bcl_latch_mem bcl_latch_mem_i
  (
    .clk   (clk),
    .por_n (por_n),
    .mem   (mif.mem)
  );

  // bus state
  bcl_state_e              state_q;
  bcl_state_e              state_d;
  logic [BCL_WCNT_W-1:0]   wcnt_q;
  logic [BCL_WCNT_W-1:0]   wcnt_d;
  logic [2:0]              idx_q;
  logic                    hit_latch_q;
  logic                    hit_status_q;
  logic [31:0]             rdata_q;
  logic [31:0]             rdata_d;
  logic                    wait_q;
  logic                    wait_d;
  logic [BCL_WEAR_W-1:0]   wear_q;
  // reset observation
  logic                    rst_meta_q;
  logic                    rst_sync_q;

  // request decode
  wire logic [2:0]  req_idx     = avs_address[BCL_ADDR_W-1:2];
  wire logic        req_aligned = (avs_address[1:0] == 2'b00);
  wire logic        req_latch   = req_aligned && !req_idx[2];
  wire logic        req_status  = req_aligned && (req_idx == BCL_IDX_STATUS);
  wire logic        in_idle     = (state_q == BCL_ST_IDLE);
  wire logic        wr_last     = (state_q == BCL_ST_WRITE) && (wcnt_q == '0);
  wire logic        wr_commit   = wr_last && hit_latch_q && avs_byteenable[0];

  // reserved bits of byte 2 stay clear
  wire logic [7:0]  wr_byte     = (idx_q == BCL_IDX_RESET_DBG)
                                  ? (avs_writedata[7:0] & BCL_RESET_DBG_MASK)
                                  : avs_writedata[7:0];

  // latch array access
  assign mif.rd_en   = in_idle && avs_read && req_latch;
  assign mif.rd_idx  = req_idx[1:0];
  assign mif.wr_en   = wr_commit;
  assign mif.wr_idx  = idx_q[1:0];
  assign mif.wr_data = wr_byte;

  // latch bytes as stored
  wire logic [7:0]  byte_a      = mif.cells[BCL_IDX_PORT_A[1:0]];
  wire logic [7:0]  byte_b      = mif.cells[BCL_IDX_PORT_B[1:0]];
  wire logic [7:0]  byte_rd     = mif.cells[BCL_IDX_RESET_DBG[1:0]];
  wire logic [7:0]  byte_bc     = mif.cells[BCL_IDX_BOOT_CLK[1:0]];
  wire logic [31:0] cells_raw   = {byte_bc, byte_rd, byte_b, byte_a};

  // applied settings rebuilt in latch layout
  wire logic [31:0] applied_raw =
    {digital_clock_phase_delay, flash_ecc_use, debug_port_select, boot_clock_speed,
     ext_reset_pin_select, debug_access_allow, 4'h0,
     port_reset_drive_mode[2*BCL_NUM_PORTS-1:16], port_reset_drive_mode[15:0]};
  wire logic        cfg_pending = (applied_raw != cells_raw);
  wire logic [31:0] status_word = {wear_q, 15'h0000, cfg_pending};

  // system reset seen through two flops
  wire logic        sys_in_reset = !rst_sync_q;

  // bus next state
  always_comb
  begin
    state_d = state_q;
    wcnt_d  = wcnt_q;
    rdata_d = rdata_q;
    wait_d  = 1'b1;
    case (state_q)
      BCL_ST_IDLE:
      begin
        if (avs_read)
        begin
          state_d = BCL_ST_READ;
        end
        else if (avs_write)
        begin
          state_d = BCL_ST_WRITE;
          wcnt_d  = WRITE_CYCLES - BCL_WCNT_W'(1);
        end
      end
      BCL_ST_READ:
      begin
        if (hit_latch_q)
        begin
          rdata_d = {24'h000000, mif.rd_data};
        end
        else if (hit_status_q)
        begin
          rdata_d = status_word;
        end
        else
        begin
          rdata_d = BCL_RDATA_RST;
        end
        wait_d  = 1'b0;
        state_d = BCL_ST_ANSWER;
      end
      BCL_ST_WRITE:
      begin
        if (wr_last)
        begin
          wait_d  = 1'b0;
          state_d = BCL_ST_ANSWER;
        end
        else
        begin
          wcnt_d = wcnt_q - BCL_WCNT_W'(1);
        end
      end
      BCL_ST_ANSWER:
      begin
        state_d = BCL_ST_IDLE;
      end
      default:
      begin
        state_d = BCL_ST_IDLE;
      end
    endcase
  end

  // bus registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= BCL_ST_IDLE;
      wcnt_q  <= '0;
      rdata_q <= BCL_RDATA_RST;
      wait_q  <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      wcnt_q  <= wcnt_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
    end
  end

  // request decode held for the transfer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_q        <= 3'h0;
      hit_latch_q  <= 1'b0;
      hit_status_q <= 1'b0;
    end
    else if (in_idle)
    begin
      idx_q        <= req_idx;
      hit_latch_q  <= req_latch;
      hit_status_q <= req_status;
    end
  end

  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      wear_q <= '0;
    end
    else if (wr_commit && (wear_q != '1))
    begin
      wear_q <= wear_q + BCL_WEAR_W'(1);
    end
  end

  // synchroniser on the system reset level
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= nrst;
      rst_sync_q <= rst_meta_q;
    end
  end

  // capture settings only while reset held
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      port_reset_drive_mode     <= {BCL_DFLT_RESET_DBG[1:0], BCL_DFLT_PORT_B, BCL_DFLT_PORT_A};
      ext_reset_pin_select      <= BCL_DFLT_RESET_DBG[BCL_XRES_BIT];
      debug_access_allow        <= BCL_DFLT_RESET_DBG[BCL_DEBUG_ACCESS_ALLOW_BIT];
      boot_clock_speed          <= BCL_DFLT_BOOT_CLK[BCL_SPEED_BIT];
      debug_port_select         <= BCL_DFLT_BOOT_CLK[BCL_DPS_LSB +: 2];
      debug_ports_off           <= (BCL_DFLT_BOOT_CLK[BCL_DPS_LSB +: 2] == BCL_DPS_OFF);
      flash_ecc_use             <= BCL_DFLT_BOOT_CLK[BCL_ECC_BIT];
      ecc_bytes_as_data         <= !BCL_DFLT_BOOT_CLK[BCL_ECC_BIT];
      digital_clock_phase_delay <= BCL_DFLT_BOOT_CLK[BCL_PHS_LSB +: 4];
    end
    else if (sys_in_reset)
    begin
      port_reset_drive_mode     <= {byte_rd[BCL_P15_LSB +: 2], byte_b, byte_a};
      ext_reset_pin_select      <= byte_rd[BCL_XRES_BIT];
      debug_access_allow        <= byte_rd[BCL_DEBUG_ACCESS_ALLOW_BIT];
      boot_clock_speed          <= byte_bc[BCL_SPEED_BIT];
      debug_port_select         <= byte_bc[BCL_DPS_LSB +: 2];
      debug_ports_off           <= (byte_bc[BCL_DPS_LSB +: 2] == BCL_DPS_OFF);
      flash_ecc_use             <= byte_bc[BCL_ECC_BIT];
      ecc_bytes_as_data         <= !byte_bc[BCL_ECC_BIT];
      digital_clock_phase_delay <= byte_bc[BCL_PHS_LSB +: 4];
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  // checks
  default clocking cb @(posedge clk); endclocking

  sequence s_capture;
    sys_in_reset;
  endsequence

  sequence s_read_issue;
    in_idle && avs_read;
  endsequence

  sequence s_read_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  property p_cfg_applied;
    disable iff (!por_n) s_capture |=> applied_raw == $past(cells_raw);
  endproperty
  a_cfg_applied: assert property (p_cfg_applied) else $error("applied config differs");

  property p_port_drive;
    disable iff (!por_n) s_capture |=> port_reset_drive_mode == $past({byte_rd[1:0], byte_b, byte_a});
  endproperty
  a_port_drive: assert property (p_port_drive) else $error("port drive not captured");

  property p_ext_reset;
    disable iff (!por_n) s_capture |=> ext_reset_pin_select == $past(byte_rd[BCL_XRES_BIT]);
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("reset pin role wrong");

  property p_debug_access;
    disable iff (!por_n) s_capture |=> debug_access_allow == $past(byte_rd[BCL_DEBUG_ACCESS_ALLOW_BIT]);
  endproperty
  a_debug_access: assert property (p_debug_access) else $error("debug gate wrong");

  property p_boot_speed;
    disable iff (!por_n) s_capture |=> boot_clock_speed == $past(byte_bc[BCL_SPEED_BIT]);
  endproperty
  a_boot_speed: assert property (p_boot_speed) else $error("boot speed wrong");

  property p_debug_off;
    disable iff (!por_n) debug_ports_off == (debug_port_select == BCL_DPS_OFF);
  endproperty
  a_debug_off: assert property (p_debug_off) else $error("debug off decode wrong");

  property p_ecc_use;
    disable iff (!por_n) s_capture |=> flash_ecc_use == $past(byte_bc[BCL_ECC_BIT])
      && ecc_bytes_as_data == !flash_ecc_use;
  endproperty
  a_ecc_use: assert property (p_ecc_use) else $error("ecc use wrong");

  property p_phase;
    disable iff (!por_n) s_capture |=> digital_clock_phase_delay == $past(byte_bc[7:4]);
  endproperty
  a_phase: assert property (p_phase) else $error("phase delay wrong");

  property p_reserved_zero;
    disable iff (!por_n) (byte_rd & ~BCL_RESET_DBG_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_hold;
    disable iff (!por_n) !sys_in_reset |=> $stable(applied_raw);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed outside reset");

  property p_read_answer;
    disable iff (!nrst) s_read_issue |=> s_read_answer;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  property p_wait_pulse;
    disable iff (!nrst) !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");

  property p_write_answer;
    disable iff (!nrst) wr_last |=> !avs_waitrequest;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer missing");

  property p_idle_wait;
    disable iff (!nrst) in_idle |-> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low while idle");

  property p_wear_step;
    disable iff (!por_n) wr_commit && (wear_q != '1)
      |=> wear_q == $past(wear_q) + BCL_WEAR_W'(1);
  endproperty
  a_wear_step: assert property (p_wear_step) else $error("wear count not stepped");

endmodule : bcl_top
